// ### rtl/ssc_defines.svh
// Offsets, field positions, reset values and timing counts of the serial command block.
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_CLK_PERIOD_NS 20
`define SSC_MS_NS         1000000
`define SSC_TENTH_S_MS    100
`define SSC_OFF_IRQ_STAT  8'h00
`define SSC_OFF_IRQ_MASK  8'h04
`define SSC_OFF_PRM232    8'h08
`define SSC_OFF_PRM485    8'h0c
`define SSC_OFF_CMD_CNT   8'h10
`define SSC_OFF_FB_CNT    8'h14
`define SSC_IRQ_REPLY     0
`define SSC_IRQ_ERROR     1
`define SSC_IRQ_ABORT     2
`define SSC_PRM_RST       28'h050a021
`define SSC_CMD_INIT      4'h1
`define SSC_CMD_POS       4'h2
`define SSC_MODE_SET232   4'h8
`define SSC_MODE_SET485   4'h9
`define SSC_MODE_STATUS   4'h0
`define SSC_MODE_CMDCNT   4'h1
`define SSC_MODE_FBCNT    4'h2
`define SSC_MODE_SPEED    4'h4
`define SSC_SET_LEN       8'h04
`define SSC_EC_ANY        7
`define SSC_EC_CMD        5
`define SSC_EC_LINK       4
`define SSC_EC_RTY        3
`define SSC_EC_T2         2
`define SSC_EC_T1         1
`define SSC_ST_POS        3
`define SSC_ST_NEG        2
`define SSC_ST_SLOW       1
`define SSC_ST_TLIM       0
`define SSC_LOW_SPEED     16'sh001e
`endif

// ### rtl/ssc_pkg.sv
// Types shared by the serial command block.
package ssc_pkg;
  typedef struct packed {
    logic [7:0] t1;
    logic [7:0] t2;
    logic [7:0] t6;
    logic [3:0] retry_count;
  } ssc_prm_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BODY = 2'b10} ssc_rx_st_t;
  typedef enum logic [2:0] {HD_IDLE = 3'b001, HD_WAIT = 3'b010, HD_SEND = 3'b100} ssc_hd_st_t;
endpackage

// ### rtl/ssc_frame_if.sv
// Carrier between the frame receiver and the command handler.
`timescale 1ns/1ns
`default_nettype none
interface ssc_frame_if;
  logic        ms_tick;
  logic [7:0]  t1;
  logic        frame_ok;
  logic        abort;
  logic        link_err;
  logic [7:0]  count;
  logic [7:0]  axis;
  logic [7:0]  cmdmode;
  logic [31:0] pay;
  modport rx (input ms_tick, t1, output frame_ok, abort, link_err, count, axis, cmdmode, pay);
  modport hd (output ms_tick, t1, input frame_ok, abort, link_err, count, axis, cmdmode, pay);
endinterface
`default_nettype wire

// ### rtl/ssc_frame_rx.sv
// Frame receiver: collects count, axis, command, payload and checksum bytes.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defines.svh"
module ssc_frame_rx (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Received bytes.
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_err_i,
  // Frame toward the handler.
  ssc_frame_if.rx         fr
);
  ssc_pkg::ssc_rx_st_t st_q, st_d;
  logic [7:0]  idx_q, idx_d, sum_q, sum_d, cnt_q, cnt_d, axis_q, axis_d, cm_q, cm_d;
  logic [31:0] pay_q, pay_d;
  logic [15:0] gap_q, gap_d, gap_lim;
  logic        ok_q, ok_d, ab_q, ab_d, le_q, le_d;

  // The gap limit is in milliseconds; the character timeout counts tenths of a second.
  assign gap_lim = 16'({8'h00, fr.t1} * `SSC_TENTH_S_MS);

  // Next state: a frame is count+3 bytes after the count byte; the sum of all bytes is zero.
  always_comb begin
    st_d = st_q; idx_d = idx_q; sum_d = sum_q; cnt_d = cnt_q; axis_d = axis_q;
    cm_d = cm_q; pay_d = pay_q; gap_d = gap_q; ok_d = 1'b0; ab_d = 1'b0; le_d = le_q;
    case (st_q)
      ssc_pkg::RX_IDLE: begin
        if (rx_valid_i) begin
          st_d = ssc_pkg::RX_BODY; cnt_d = rx_data_i; sum_d = rx_data_i;
          idx_d = 8'h00; gap_d = 16'h0000; le_d = rx_err_i; pay_d = 32'h0;
        end
      end
      ssc_pkg::RX_BODY: begin
        if (rx_valid_i) begin
          gap_d = 16'h0000;
          idx_d = idx_q + 8'h01;
          sum_d = sum_q + rx_data_i;
          le_d  = le_q | rx_err_i;
          if (idx_q == 8'h00) axis_d = rx_data_i;
          else if (idx_q == 8'h01) cm_d = rx_data_i;
          else if (idx_q < 8'h06) pay_d[8*(idx_q-8'h02) +: 8] = rx_data_i;
          // Only the first four payload bytes are kept; a longer frame is answered as bad count.
          if (idx_q == cnt_q + 8'h02) begin
            st_d = ssc_pkg::RX_IDLE;
            ok_d = (sum_q + rx_data_i) == 8'h00;
          end
        end else if (fr.ms_tick) begin
          gap_d = gap_q + 16'h0001;
          if (gap_q + 16'h0001 >= gap_lim) begin
            st_d = ssc_pkg::RX_IDLE;
            ab_d = 1'b1;
          end
        end
      end
      default: st_d = ssc_pkg::RX_IDLE;
    endcase
  end

  // Registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ssc_pkg::RX_IDLE; idx_q <= 8'h00; sum_q <= 8'h00; cnt_q <= 8'h00;
      axis_q <= 8'h00; cm_q <= 8'h00; pay_q <= 32'h0; gap_q <= 16'h0000;
      ok_q <= 1'b0; ab_q <= 1'b0; le_q <= 1'b0;
    end else begin
      st_q <= st_d; idx_q <= idx_d; sum_q <= sum_d; cnt_q <= cnt_d;
      axis_q <= axis_d; cm_q <= cm_d; pay_q <= pay_d; gap_q <= gap_d;
      ok_q <= ok_d; ab_q <= ab_d; le_q <= le_d;
    end
  end

  assign fr.frame_ok = ok_q;
  assign fr.abort    = ab_q;
  assign fr.link_err = le_q;
  assign fr.count    = cnt_q;
  assign fr.axis     = axis_q;
  assign fr.cmdmode  = cm_q;
  assign fr.pay      = pay_q;

  // A frame never ends both well and by timeout.
  chk_rx_excl: assert property (@(posedge clk_i) disable iff (rst_i) !(ok_q && ab_q))
    else $error("frame both accepted and aborted");
endmodule
`default_nettype wire

// ### rtl/ssc_cmd_top.sv
// Serial command handler: protocol setup and status, counter and speed readouts.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defines.svh"
module ssc_cmd_top #(
  parameter int MS_CYC = `SSC_MS_NS / `SSC_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // Serial byte stream; link_485_i says which link the exchange uses.
  input  wire logic        link_485_i,
  input  wire logic [7:0]  axis_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_err_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  // Drive state.
  input  wire logic [1:0]  control_mode_i,
  input  wire logic [15:0] speed_rpm_i,
  input  wire logic        torque_limited_i,
  input  wire logic        cmd_pulse_i,
  input  wire logic        cmd_dir_neg_i,
  input  wire logic        enc_pulse_i,
  input  wire logic        enc_dir_neg_i
);
  ssc_frame_if fr ();
  ssc_frame_rx u_rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .rx_valid_i (rx_valid_i),
    .rx_data_i  (rx_data_i),
    .rx_err_i   (rx_err_i),
    .fr         (fr)
  );

  // Signed step of a position counter by one pulse.
  function automatic logic [31:0] step(input logic [31:0] c, input logic p, input logic neg);
    step = !p ? c : (neg ? c - 32'h1 : c + 32'h1);
  endfunction

  ssc_pkg::ssc_hd_st_t st_q, st_d;
  ssc_pkg::ssc_prm_t   prm_q [2];
  ssc_pkg::ssc_prm_t   prm_d [2];
  ssc_pkg::ssc_prm_t   pend_q, pend_d, act;
  logic [7:0]  rep_q [9];
  logic [7:0]  rep_d [9];
  logic [3:0]  len_q, len_d, idx_q, idx_d;
  logic        pv_q, pv_d, pl_q, pl_d, err_q, err_d, lk_q, lk_d;
  logic [15:0] pre_q, pre_d, dly_q, dly_d, lim_q, lim_d;
  logic [31:0] ccnt_q, ccnt_d, fcnt_q, fcnt_d, rd_q, rd_d;
  logic [2:0]  stat_q, stat_d, mask_q, mask_d;
  logic        ack_q, ack_d, irq_q, irq_d, txv_q, txv_d;
  logic [7:0]  txd_q, txd_d;
  logic        accept, wr, done;
  logic [7:0]  stb, ec;
  logic [3:0]  cmd, mode;
  logic signed [15:0] spd;

  assign act  = prm_q[link_485_i];
  assign cmd  = fr.cmdmode[3:0];
  assign mode = fr.cmdmode[7:4];
  assign spd  = signed'(speed_rpm_i);
  assign accept = (st_q == ssc_pkg::HD_IDLE) && fr.frame_ok && (fr.axis == axis_i);
  assign done = (st_q == ssc_pkg::HD_SEND) && txv_q && tx_ready_i && (idx_q == len_q);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign fr.t1 = act.t1;
  assign fr.ms_tick = (pre_q == 16'(MS_CYC - 1));

  // Status byte of the drive.
  always_comb begin
    stb = 8'h00;
    stb[`SSC_ST_POS]  = spd > 16'sh0000;
    stb[`SSC_ST_NEG]  = spd < 16'sh0000;
    stb[`SSC_ST_SLOW] = (spd < `SSC_LOW_SPEED) && (spd > -`SSC_LOW_SPEED);
    stb[`SSC_ST_TLIM] = torque_limited_i;
  end

  // Reply builder, exchange sequencer and pending setup.
  always_comb begin
    st_d = st_q; len_d = len_q; idx_d = idx_q; pend_d = pend_q; pv_d = pv_q; pl_d = pl_q;
    lim_d = lim_q; dly_d = dly_q; txv_d = txv_q; txd_d = txd_q; err_d = 1'b0; lk_d = lk_q;
    rep_d = rep_q; ec = 8'h00;
    pre_d = fr.ms_tick ? 16'h0000 : pre_q + 16'h0001;
    case (st_q)
      ssc_pkg::HD_IDLE: begin
        if (accept) begin
          ec[`SSC_EC_LINK] = fr.link_err;
          pv_d = 1'b0;
          pl_d = mode[0];
          lk_d = link_485_i;
          rep_d[1] = fr.axis;
          rep_d[2] = fr.cmdmode;
          if (cmd == `SSC_CMD_INIT && (mode == `SSC_MODE_SET232 || mode == `SSC_MODE_SET485)
              && fr.count == `SSC_SET_LEN) begin
            pend_d = '{t1: fr.pay[7:0], t2: fr.pay[15:8], t6: fr.pay[23:16],
                       retry_count: fr.pay[27:24]};
            ec[`SSC_EC_T1]  = fr.pay[7:0] == 8'h00;
            ec[`SSC_EC_T2]  = fr.pay[15:8] == 8'h00;
            ec[`SSC_EC_RTY] = fr.pay[31:28] != 4'h0;
            ec[`SSC_EC_CMD] = 16'({8'h00, fr.pay[23:16]})
                              >= 16'({8'h00, fr.pay[15:8]} * `SSC_TENTH_S_MS);
            pv_d = ec[`SSC_EC_T1:`SSC_EC_T1+0] == 1'b0 && ec[5:1] == 5'h00;
            len_d = 4'h1;
          end else if (cmd == `SSC_CMD_POS && fr.count == 8'h00
                       && mode == `SSC_MODE_STATUS) begin
            rep_d[3] = {6'h00, control_mode_i};
            rep_d[4] = stb;
            len_d = 4'h3;
          end else if (cmd == `SSC_CMD_POS && fr.count == 8'h00
                       && (mode == `SSC_MODE_CMDCNT || mode == `SSC_MODE_FBCNT)) begin
            {rep_d[6], rep_d[5], rep_d[4], rep_d[3]} =
              (mode == `SSC_MODE_CMDCNT) ? ccnt_q : fcnt_q;
            len_d = 4'h5;
          end else if (cmd == `SSC_CMD_POS && fr.count == 8'h00
                       && mode == `SSC_MODE_SPEED) begin
            rep_d[3] = speed_rpm_i[7:0];
            rep_d[4] = speed_rpm_i[15:8];
            len_d = 4'h3;
          end else begin
            // Unknown command or wrong data count: the error code alone goes back.
            ec[`SSC_EC_CMD] = 1'b1;
            len_d = 4'h1;
          end
          ec[`SSC_EC_ANY] = |ec[6:0];
          rep_d[0] = {4'h0, len_d};
          rep_d[len_d + 4'h2] = ec;
          rep_d[len_d + 4'h3] = 8'h00;
          for (int i = 0; i < 8; i++) begin
            if (4'(i) < len_d + 4'h3) rep_d[len_d + 4'h3] = rep_d[len_d + 4'h3] - rep_d[i];
          end
          err_d = ec[`SSC_EC_ANY];
          // The delay clock restarts here, so a millisecond is never cut short.
          pre_d = 16'h0000;
          dly_d = 16'h0000;
          lim_d = (16'({8'h00, act.t6}) < 16'({8'h00, act.t2} * `SSC_TENTH_S_MS)) ?
                  16'({8'h00, act.t6}) : 16'({8'h00, act.t2} * `SSC_TENTH_S_MS);
          st_d = ssc_pkg::HD_WAIT;
        end
      end
      ssc_pkg::HD_WAIT: begin
        if (dly_q >= lim_q) begin
          st_d = ssc_pkg::HD_SEND; txv_d = 1'b1; txd_d = rep_q[0]; idx_d = 4'h0;
          len_d = len_q + 4'h3;
        end else if (fr.ms_tick) begin
          dly_d = dly_q + 16'h0001;
        end
      end
      ssc_pkg::HD_SEND: begin
        if (txv_q && tx_ready_i) begin
          if (idx_q == len_q) begin
            txv_d = 1'b0; st_d = ssc_pkg::HD_IDLE;
          end else begin
            idx_d = idx_q + 4'h1; txd_d = rep_q[idx_q + 4'h1];
          end
        end
      end
      default: st_d = ssc_pkg::HD_IDLE;
    endcase
  end

  // Counters, parameter sets and software registers.
  always_comb begin
    ccnt_d = step(ccnt_q, cmd_pulse_i, cmd_dir_neg_i);
    fcnt_d = step(fcnt_q, enc_pulse_i, enc_dir_neg_i);
    prm_d = prm_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && wb_sel_i[0] && wb_adr_i == `SSC_OFF_IRQ_STAT) stat_d = stat_q & ~wb_dat_i[2:0];
    if (wr && wb_sel_i[0] && wb_adr_i == `SSC_OFF_IRQ_MASK) mask_d = wb_dat_i[2:0];
    if (wr && wb_sel_i == 4'hf && wb_adr_i == `SSC_OFF_PRM232) prm_d[0] = wb_dat_i[27:0];
    if (wr && wb_sel_i == 4'hf && wb_adr_i == `SSC_OFF_PRM485) prm_d[1] = wb_dat_i[27:0];
    // A setup lands only once its own reply is out, so that exchange kept the old set.
    if (done && pv_q) prm_d[pl_q] = pend_q;
    // Events are applied after the clear so a coincident event is kept.
    if (done) stat_d[`SSC_IRQ_REPLY] = 1'b1;
    if (err_q) stat_d[`SSC_IRQ_ERROR] = 1'b1;
    if (fr.abort) stat_d[`SSC_IRQ_ABORT] = 1'b1;
    irq_d = |(stat_d & mask_d);
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    case (wb_adr_i)
      `SSC_OFF_IRQ_STAT: rd_d = {29'h0, stat_q};
      `SSC_OFF_IRQ_MASK: rd_d = {29'h0, mask_q};
      `SSC_OFF_PRM232:   rd_d = {4'h0, prm_q[0]};
      `SSC_OFF_PRM485:   rd_d = {4'h0, prm_q[1]};
      `SSC_OFF_CMD_CNT:  rd_d = ccnt_q;
      `SSC_OFF_FB_CNT:   rd_d = fcnt_q;
      default:           rd_d = 32'h0;
    endcase
  end

  // Registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ssc_pkg::HD_IDLE; len_q <= 4'h0; idx_q <= 4'h0; pend_q <= `SSC_PRM_RST;
      pv_q <= 1'b0; pl_q <= 1'b0; lk_q <= 1'b0; lim_q <= 16'h0; dly_q <= 16'h0;
      pre_q <= 16'h0; txv_q <= 1'b0; txd_q <= 8'h00; err_q <= 1'b0;
      for (int i = 0; i < 9; i++) rep_q[i] <= 8'h00;
      prm_q[0] <= `SSC_PRM_RST; prm_q[1] <= `SSC_PRM_RST;
      ccnt_q <= 32'h0; fcnt_q <= 32'h0; stat_q <= 3'h0; mask_q <= 3'h0;
      irq_q <= 1'b0; ack_q <= 1'b0; rd_q <= 32'h0;
    end else begin
      st_q <= st_d; len_q <= len_d; idx_q <= idx_d; pend_q <= pend_d;
      pv_q <= pv_d; pl_q <= pl_d; lk_q <= lk_d; lim_q <= lim_d; dly_q <= dly_d;
      pre_q <= pre_d; txv_q <= txv_d; txd_q <= txd_d; err_q <= err_d;
      rep_q <= rep_d; prm_q <= prm_d;
      ccnt_q <= ccnt_d; fcnt_q <= fcnt_d; stat_q <= stat_d; mask_q <= mask_d;
      irq_q <= irq_d; ack_q <= ack_d; rd_q <= rd_d;
    end
  end

  assign wb_dat_o   = rd_q;
  assign wb_ack_o   = ack_q;
  assign irq_o      = irq_q;
  assign tx_valid_o = txv_q;
  assign tx_data_o  = txd_q;

  // Checks beside the logic.
  chk_cmd_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_pulse_i && !cmd_dir_neg_i |=> ccnt_q == $past(ccnt_q) + 32'h1)
    else $error("command counter missed a forward pulse");
  chk_fb_cnt_back: assert property (@(posedge clk_i) disable iff (rst_i)
    enc_pulse_i && enc_dir_neg_i |=> fcnt_q == $past(fcnt_q) - 32'h1)
    else $error("feedback counter missed a reverse pulse");
  chk_axis_echo: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ssc_pkg::HD_SEND && idx_q == 4'h1 |-> tx_data_o == rep_q[1])
    else $error("reply axis byte out of place");
  chk_delay_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_valid_o) |-> $past(dly_q) >= $past(lim_q))
    else $error("reply started before the minimum delay");
  chk_setup_late: assert property (@(posedge clk_i) disable iff (rst_i)
    prm_q[0] != $past(prm_q[0]) |-> $past(done) || $past(wr))
    else $error("parameter set changed during an exchange");
  chk_setup_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    done && pv_q && !pl_q |=> prm_q[0] == $past(pend_q))
    else $error("valid setup not applied after its reply");
  chk_bad_count: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && cmd == `SSC_CMD_POS && fr.count != 8'h00 |=> rep_q[0] == 8'h01
    && rep_q[3][`SSC_EC_CMD] && rep_q[3][`SSC_EC_ANY])
    else $error("bad count not answered with error code only");
  chk_speed_low: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && cmd == `SSC_CMD_POS && fr.count == 8'h00 && mode == `SSC_MODE_SPEED
    |=> rep_q[3] == $past(speed_rpm_i[7:0]) && rep_q[4] == $past(speed_rpm_i[15:8]))
    else $error("speed bytes out of order");
  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");
  cov_status_read: cover property (@(posedge clk_i) disable iff (rst_i)
    accept && mode == `SSC_MODE_STATUS && cmd == `SSC_CMD_POS);
  cov_setup_done: cover property (@(posedge clk_i) disable iff (rst_i) done && pv_q);
  cov_error_reply: cover property (@(posedge clk_i) disable iff (rst_i) err_q);
  cov_rx_abort: cover property (@(posedge clk_i) disable iff (rst_i) fr.abort);
endmodule
`default_nettype wire

// ### dv/ssc_host_model.sv
// Host controller model: sends command frames and collects the reply bytes.
`timescale 1ns/1ns
`default_nettype none
module ssc_host_model (
  // Clock.
  input  wire logic       clk_i,
  // Bytes toward the block.
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_err_o,
  // Bytes from the block.
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] reply_q[$];
  logic       slow = 1'b0;
  logic [1:0] tick = 2'h0;

  // Quiet lines at time zero.
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_err_o   = 1'b0;
    tx_ready_o = 1'b0;
  end

  // A slow host takes one byte in four cycles, so the block has to hold each byte.
  always @(posedge clk_i) begin
    tick <= tick + 2'h1;
    if (tx_valid_i && tx_ready_o)
      reply_q.push_back(tx_data_i);
    tx_ready_o <= slow ? (tick == 2'h3) : 1'b1;
  end

  // Sends the bytes and a closing checksum; released data lines show the inverse value.
  task automatic send(input logic [7:0] f[$], input logic err);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (f[i]) sum -= f[i];
    f.push_back(sum);
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= f[i];
      rx_err_o   <= err;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~f[i];
      rx_err_o   <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### dv/test_servo_serial_cmd_status_readout.sv
// Self-checking bench of the serial command block with a host model on the byte stream.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %0h exp %0h", $time, (a), (b)); end end
module test_servo_serial_cmd_status_readout;
  localparam int         MS = 10;
  localparam logic [7:0] AX = 8'h03;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, link_485_i;
  logic        rx_valid_i, rx_err_i, tx_valid_o, tx_ready_i, torque_limited_i;
  logic        cmd_pulse_i, cmd_dir_neg_i, enc_pulse_i, enc_dir_neg_i;
  logic [7:0]  wb_adr_i, rx_data_i, tx_data_o, axis_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0]  control_mode_i;
  logic [15:0] speed_rpm_i;
  logic [7:0]  rep[$];
  int          n_fail = 0;
  int          checks_done = 0;
  int          lat;

  ssc_cmd_top #(.MS_CYC(MS)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link_485_i(link_485_i),
    .axis_i(axis_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .control_mode_i(control_mode_i), .speed_rpm_i(speed_rpm_i),
    .torque_limited_i(torque_limited_i), .cmd_pulse_i(cmd_pulse_i),
    .cmd_dir_neg_i(cmd_dir_neg_i), .enc_pulse_i(enc_pulse_i), .enc_dir_neg_i(enc_dir_neg_i)
  );
  ssc_host_model i_host (
    .clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_err_o(rx_err_i),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A wait that ran out is a mismatch; the run cannot go on sensibly after it.
  task automatic hang();
    n_fail++;
    $display("ERROR %0t wait got %0h exp %0h", $time, 0, 1);
    end_of_test();
  endtask

  // Classic single Wishbone cycle; rd holds the data taken at the ack edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) hang();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Sends one frame, gathers an n-byte reply and checks its framing; lat is the reply wait.
  task automatic req(input logic [7:0] f[$], input logic err, input int n);
    logic [7:0] sum;
    int         k;
    i_host.send(f, err);
    k = 0;
    while (tx_valid_o !== 1'b1 && k < 9000) begin
      @(posedge clk_i);
      k++;
    end
    lat = k;
    while (i_host.reply_q.size() < n && k < 9000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 9000) hang();
    repeat (4) @(posedge clk_i);
    rep = i_host.reply_q;
    i_host.reply_q.delete();
    sum = 8'h00;
    foreach (rep[i]) sum += rep[i];
    `CHK(sum, 8'h00)
    `CHK(rep[0], 8'(n - 4))
    `CHK(rep[1], AX)
    `CHK(rep[2], f[2])
  endtask

  // Pulses on the command or the encoder counter input.
  task automatic pulses(input logic enc, input logic neg, input int k);
    repeat (k) begin
      @(posedge clk_i);
      cmd_pulse_i   <= !enc;
      enc_pulse_i   <= enc;
      cmd_dir_neg_i <= neg;
      enc_dir_neg_i <= neg;
      @(posedge clk_i);
      cmd_pulse_i <= 1'b0;
      enc_pulse_i <= 1'b0;
    end
  endtask

  task automatic t_regs();
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0050a021)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0050a021)
    wb(1'b1, 8'h30, 32'hffffffff);
    wb(1'b0, 8'h30, 32'h0);
    `CHK(rd, 32'h0)
    $display("test regs done");
  endtask

  // Every control mode, with speeds on both sides of zero and of the low-speed limit.
  task automatic t_status();
    logic signed [15:0] sp[4] = '{16'sh0064, -16'sh00c8, 16'sh001d, -16'sh001e};
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      control_mode_i   <= m[1:0];
      speed_rpm_i      <= sp[m];
      torque_limited_i <= m[1];
      req('{8'h00, AX, 8'h02}, 1'b0, 7);
      `CHK(rep[3], m[7:0])
      `CHK(rep[4][3:2], {sp[m] > 0, sp[m] < 0})
      `CHK(rep[4][1], sp[m] > -30 && sp[m] < 30)
      `CHK(rep[4][0], m[1])
      req('{8'h00, AX, 8'h42}, 1'b0, 7);
      `CHK({rep[4], rep[3]}, sp[m])
      `CHK(rep[5], 8'h00)
    end
    $display("test status done");
  endtask

  // Counters read with a slow host, so every reply byte must be held.
  task automatic t_count();
    i_host.slow <= 1'b1;
    pulses(1'b0, 1'b0, 5);
    pulses(1'b0, 1'b1, 2);
    pulses(1'b1, 1'b1, 7);
    req('{8'h00, AX, 8'h12}, 1'b0, 9);
    `CHK({rep[6], rep[5], rep[4], rep[3]}, 32'h00000003)
    req('{8'h00, AX, 8'h22}, 1'b0, 9);
    `CHK({rep[6], rep[5], rep[4], rep[3]}, 32'hfffffff9)
    wb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'hfffffff9)
    i_host.slow <= 1'b0;
    $display("test count done");
  endtask

  // The setup reply still keeps the old delay; the next command uses the new one.
  task automatic t_setup();
    req('{8'h00, AX, 8'h02}, 1'b0, 7);
    `CHK(lat >= 2 * MS && lat < 1000 * MS, 1'b1)
    req('{8'h04, AX, 8'h81, 8'h03, 8'h04, 8'h05, 8'h02}, 1'b0, 5);
    `CHK(rep[3], 8'h00)
    `CHK(lat >= 2 * MS && lat < 5 * MS, 1'b1)
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h00304052)
    req('{8'h00, AX, 8'h02}, 1'b0, 7);
    `CHK(lat >= 5 * MS && lat < 400 * MS, 1'b1)
    @(posedge clk_i);
    link_485_i <= 1'b1;
    req('{8'h04, AX, 8'h91, 8'h00, 8'h00, 8'h01, 8'h10}, 1'b0, 5);
    `CHK(rep[3], 8'hae)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0050a021)
    $display("test setup done");
  endtask

  // A wrong data count with link faults raises a masked-in error interrupt.
  task automatic t_irq();
    wb(1'b1, 8'h00, 32'h7);
    wb(1'b1, 8'h04, 32'h2);
    req('{8'h02, AX, 8'h02, 8'h00, 8'h00}, 1'b1, 5);
    `CHK(rep[3], 8'hb0)
    `CHK(irq_o, 1'b1)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd[1], 1'b1)
    wb(1'b1, 8'h00, 32'h7);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd[2:0], 3'h0)
    `CHK(irq_o, 1'b0)
    $display("test irq done");
  endtask

  // Reset for six cycles, then the scenarios in turn.
  initial begin
    rst_i            = 1'b1;
    wb_cyc_i         = 1'b0;
    wb_stb_i         = 1'b0;
    wb_we_i          = 1'b0;
    wb_adr_i         = 8'h00;
    wb_sel_i         = 4'hf;
    wb_dat_i         = 32'h0;
    link_485_i       = 1'b0;
    axis_i           = AX;
    control_mode_i   = 2'h0;
    speed_rpm_i      = 16'h0000;
    torque_limited_i = 1'b0;
    cmd_pulse_i      = 1'b0;
    cmd_dir_neg_i    = 1'b0;
    enc_pulse_i      = 1'b0;
    enc_dir_neg_i    = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_status();
    t_count();
    t_setup();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
